// >>> hdl/mdr_pkg.sv
package mdr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_STATUS = 8'h32;
    localparam logic [7:0] ADDR_X_MSB  = 8'h33;
    localparam logic [7:0] ADDR_X_LSB  = 8'h34;
    localparam logic [7:0] ADDR_Y_MSB  = 8'h35;
    localparam logic [7:0] ADDR_Y_LSB  = 8'h36;
    localparam logic [7:0] ADDR_Z_MSB  = 8'h37;
    localparam logic [7:0] ADDR_Z_LSB  = 8'h38;

    // Status field positions
    localparam int BIT_XYZOW = 7;
    localparam int BIT_ZOW   = 6;
    localparam int BIT_YOW   = 5;
    localparam int BIT_XOW   = 4;
    localparam int BIT_XYZDR = 3;
    localparam int BIT_ZDR   = 2;
    localparam int BIT_YDR   = 1;
    localparam int BIT_XDR   = 0;

    // Axis indices
    localparam int AXIS_X = 0;
    localparam int AXIS_Y = 1;
    localparam int AXIS_Z = 2;

    // Values after reset, and the value read back from an unmapped address
    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET   = 16'h0000;
    localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

endpackage

// >>> hdl/mdr_axis.sv
`timescale 1ns/1ps

// One magnetometer axis: result holding register plus its ready and overwrite flags
module mdr_axis
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        acq_done,
    input  wire logic [15:0] acq_data,
    input  wire logic        msb_read,
    output logic             ready,
    output logic             overwrite,
    output logic             ow_event,
    output logic [15:0]      data
);

    typedef struct packed
    {
        logic        ready;
        logic        overwrite;
        logic [15:0] data;
    } mdr_axis_type;

    mdr_axis_type st;
    mdr_axis_type next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // A completion while ready is still set means the unread value is lost
    assign ow_event = acq_done & st.ready;

    always_comb
    begin
        next_st = st;
        // Clear first so that a completion in the same cycle wins
        if (msb_read)
        begin
            next_st.ready     = 1'b0;
            next_st.overwrite = 1'b0;
        end
        if (acq_done)
        begin
            next_st.data  = acq_data;
            next_st.ready = 1'b1;
            if (st.ready)
            begin
                next_st.overwrite = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '{ready: 1'b0, overwrite: 1'b0, data: mdr_pkg::DATA_RESET};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign ready     = st.ready;
    assign overwrite = st.overwrite;
    assign data      = st.data;

    ////////////////////////////////////////////////////////////////////////////////
    sequence seq_lost_value;
        acq_done && ready;
    endsequence

    AST_AXIS_OW_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_lost_value |=> overwrite && ready)
        else $error("overwrite not set on lost value");

    AST_AXIS_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        msb_read && !acq_done |=> !ready && !overwrite)
        else $error("high byte read did not clear axis flags");

    AST_AXIS_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_b)
        acq_done |=> ready && data == $past(acq_data))
        else $error("axis result not captured");

endmodule

// >>> hdl/mdr_status.sv
`timescale 1ns/1ps

module mdr_status
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [2:0]  acq_done,
    input  wire logic [15:0] acq_data_x,
    input  wire logic [15:0] acq_data_y,
    input  wire logic [15:0] acq_data_z,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_addr,
    output logic [7:0]       rd_data,
    output logic [7:0]       mag_ready_status
);

    typedef struct packed
    {
        logic [7:0] rd_data;
        logic [2:0] set_done;
        logic [2:0] msb_seen;
        logic       xyzdr;
        logic       xyzow;
    } mdr_status_type;

    mdr_status_type st;
    mdr_status_type next_st;

    logic [2:0]  msb_read;
    logic [2:0]  ready;
    logic [2:0]  overwrite;
    logic [2:0]  ow_event;
    logic [15:0] data_x;
    logic [15:0] data_y;
    logic [15:0] data_z;
    logic        set_now;
    logic [2:0]  seen_now;
    logic [7:0]  status_word;

    function automatic logic is_read(input logic en, input logic [7:0] addr,
                                     input logic [7:0] target);
        is_read = en && (addr == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // High-byte reads are the clear strobes
    assign msb_read[mdr_pkg::AXIS_X] = is_read(rd_en, rd_addr, mdr_pkg::ADDR_X_MSB);
    assign msb_read[mdr_pkg::AXIS_Y] = is_read(rd_en, rd_addr, mdr_pkg::ADDR_Y_MSB);
    assign msb_read[mdr_pkg::AXIS_Z] = is_read(rd_en, rd_addr, mdr_pkg::ADDR_Z_MSB);

    mdr_axis u_axis_x
    (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .acq_done  (acq_done[mdr_pkg::AXIS_X]),
        .acq_data  (acq_data_x),
        .msb_read  (msb_read[mdr_pkg::AXIS_X]),
        .ready     (ready[mdr_pkg::AXIS_X]),
        .overwrite (overwrite[mdr_pkg::AXIS_X]),
        .ow_event  (ow_event[mdr_pkg::AXIS_X]),
        .data      (data_x)
    );

    mdr_axis u_axis_y
    (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .acq_done  (acq_done[mdr_pkg::AXIS_Y]),
        .acq_data  (acq_data_y),
        .msb_read  (msb_read[mdr_pkg::AXIS_Y]),
        .ready     (ready[mdr_pkg::AXIS_Y]),
        .overwrite (overwrite[mdr_pkg::AXIS_Y]),
        .ow_event  (ow_event[mdr_pkg::AXIS_Y]),
        .data      (data_y)
    );

    mdr_axis u_axis_z
    (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .acq_done  (acq_done[mdr_pkg::AXIS_Z]),
        .acq_data  (acq_data_z),
        .msb_read  (msb_read[mdr_pkg::AXIS_Z]),
        .ready     (ready[mdr_pkg::AXIS_Z]),
        .overwrite (overwrite[mdr_pkg::AXIS_Z]),
        .ow_event  (ow_event[mdr_pkg::AXIS_Z]),
        .data      (data_z)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Status word built from live flag state, so a read is never stale
    always_comb
    begin
        status_word                       = mdr_pkg::STATUS_RESET;
        status_word[mdr_pkg::BIT_XYZOW]   = st.xyzow;
        status_word[mdr_pkg::BIT_ZOW]     = overwrite[mdr_pkg::AXIS_Z];
        status_word[mdr_pkg::BIT_YOW]     = overwrite[mdr_pkg::AXIS_Y];
        status_word[mdr_pkg::BIT_XOW]     = overwrite[mdr_pkg::AXIS_X];
        status_word[mdr_pkg::BIT_XYZDR]   = st.xyzdr;
        status_word[mdr_pkg::BIT_ZDR]     = ready[mdr_pkg::AXIS_Z];
        status_word[mdr_pkg::BIT_YDR]     = ready[mdr_pkg::AXIS_Y];
        status_word[mdr_pkg::BIT_XDR]     = ready[mdr_pkg::AXIS_X];
    end

    // A full set exists once every axis has completed since the last set
    assign set_now  = &(st.set_done | acq_done);
    assign seen_now = st.msb_seen | msb_read;

    always_comb
    begin
        next_st = st;

        // Register read port; the reply is taken at the same edge as any clear
        if (rd_en)
        begin
            unique case (rd_addr)
                mdr_pkg::ADDR_STATUS: next_st.rd_data = status_word;
                mdr_pkg::ADDR_X_MSB:  next_st.rd_data = data_x[15:8];
                mdr_pkg::ADDR_X_LSB:  next_st.rd_data = data_x[7:0];
                mdr_pkg::ADDR_Y_MSB:  next_st.rd_data = data_y[15:8];
                mdr_pkg::ADDR_Y_LSB:  next_st.rd_data = data_y[7:0];
                mdr_pkg::ADDR_Z_MSB:  next_st.rd_data = data_z[15:8];
                mdr_pkg::ADDR_Z_LSB:  next_st.rd_data = data_z[7:0];
                default:              next_st.rd_data = mdr_pkg::UNMAPPED_VAL;
            endcase
        end

        // Per-axis completion tracking toward a full set
        next_st.set_done = set_now ? 3'h0 : (st.set_done | acq_done);

        // High-byte read tracking; clears of the combined flags wait for all three
        next_st.msb_seen = seen_now;
        if (&seen_now)
        begin
            next_st.xyzdr    = 1'b0;
            next_st.xyzow    = 1'b0;
            next_st.msb_seen = 3'h0;
        end

        // Sets come last so they win over a clear in the same cycle
        if (set_now)
        begin
            next_st.xyzdr    = 1'b1;
            next_st.msb_seen = 3'h0;
        end
        if (|ow_event)
        begin
            next_st.xyzow    = 1'b1;
            next_st.msb_seen = 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '{rd_data: mdr_pkg::STATUS_RESET, set_done: 3'h0, msb_seen: 3'h0,
                    xyzdr: 1'b0, xyzow: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data          = st.rd_data;
    assign mag_ready_status = status_word;

    ////////////////////////////////////////////////////////////////////////////////
    sequence seq_status_read;
        rd_en && rd_addr == mdr_pkg::ADDR_STATUS;
    endsequence

    sequence seq_last_msb;
        st.xyzdr && &seen_now && !set_now && !(|ow_event);
    endsequence

    AST_STATUS_LIVE: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_status_read |=> rd_data == $past(status_word))
        else $error("status read returned stale value");

    AST_XYZOW_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        |ow_event |=> mag_ready_status[mdr_pkg::BIT_XYZOW])
        else $error("combined overwrite not set");

    AST_XYZ_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_last_msb |=> !mag_ready_status[mdr_pkg::BIT_XYZDR]
                         && !mag_ready_status[mdr_pkg::BIT_XYZOW])
        else $error("combined flags not cleared after all high bytes");

    AST_XYZDR_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        set_now |=> mag_ready_status[mdr_pkg::BIT_XYZDR] && st.set_done == 3'h0)
        else $error("combined ready not set on full set");

    AST_XYZDR_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        st.xyzdr && !(&seen_now) |=> st.xyzdr)
        else $error("combined ready dropped before all high bytes read");

    AST_X_READY: assert property (@(posedge mclk) disable iff (!rst_b)
        acq_done[mdr_pkg::AXIS_X] ##1 (rd_en && rd_addr == mdr_pkg::ADDR_X_MSB)
        |=> !mag_ready_status[mdr_pkg::BIT_XDR] || $past(acq_done[mdr_pkg::AXIS_X]))
        else $error("x ready not cleared by high byte read");

    AST_MSB_DATA: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_en && rd_addr == mdr_pkg::ADDR_Z_MSB |=> rd_data == $past(data_z[15:8]))
        else $error("z high byte read mismatch");

    AST_TRACK_RESET: assert property (@(posedge mclk) disable iff (!rst_b)
        set_now || |ow_event |=> st.msb_seen == 3'h0)
        else $error("read tracking not reset on set");

endmodule

// >>> verif/mdr_host.sv
`timescale 1ns/1ps

// Host side of the read port: one read per request, reply taken the cycle after the strobe
module mdr_host
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       req,
    input  wire logic [7:0] req_addr,
    input  wire logic [7:0] rd_data,
    output logic            rd_en,
    output logic [7:0]      rd_addr,
    output logic            ack,
    output logic [7:0]      rdata
);
    logic [1:0] phase;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase   <= 2'h0;
            rd_en   <= 1'b0;
            rd_addr <= 8'h00;
            ack     <= 1'b0;
            rdata   <= 8'h00;
        end
        else
        begin
            case (phase)
                2'h0:
                begin
                    if (req)
                    begin
                        rd_en   <= 1'b1;
                        rd_addr <= req_addr;
                        phase   <= 2'h1;
                    end
                end
                2'h1:
                begin
                    rd_en   <= 1'b0;
                    // Address is meaningless once released, so never leave it looking valid
                    rd_addr <= ~rd_addr;
                    phase   <= 2'h2;
                end
                2'h2:
                begin
                    // Reply must be there exactly one cycle after the strobe
                    rdata <= rd_data;
                    ack   <= 1'b1;
                    phase <= 2'h3;
                end
                default:
                begin
                    ack   <= 1'b0;
                    phase <= 2'h0;
                end
            endcase
        end
    end
endmodule

// >>> verif/mdr_status_tb.sv
`timescale 1ns/1ps

module mdr_status_tb;
    logic        mclk     = 1'b0;
    logic        rst_b    = 1'b0;
    logic [2:0]  acq_done = 3'h0;
    logic [15:0] dx       = 16'h0000;
    logic [15:0] dy       = 16'h0000;
    logic [15:0] dz       = 16'h0000;
    logic        req      = 1'b0;
    logic [7:0]  req_addr = 8'h00;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic [7:0]  status;
    logic        ack;
    logic [7:0]  rdata;
    int          fails       = 0;
    int          checks_done = 0;

    always #20 mclk = ~mclk;

    mdr_status i_mdr_status (.mclk(mclk), .rst_b(rst_b), .acq_done(acq_done),
        .acq_data_x(dx), .acq_data_y(dy), .acq_data_z(dz), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .mag_ready_status(status));

    mdr_host i_mdr_host (.mclk(mclk), .rst_b(rst_b), .req(req), .req_addr(req_addr),
        .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr), .ack(ack), .rdata(rdata));

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [7:0] exp_d, input logic [7:0] exp_s);
        int n;
        @(posedge mclk);
        req      <= 1'b1;
        req_addr <= a;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            fails++;
            end_sim();
        end
        req <= 1'b0;
        chk("rd_data", rdata, exp_d);
        chk("status", status, exp_s);
    endtask

    // Y and Z get values derived from X so byte order slips show up per axis
    task acq(input logic [2:0] mask, input logic [15:0] v);
        @(posedge mclk);
        acq_done <= mask;
        dx       <= v;
        dy       <= ~v;
        dz       <= {v[7:0], v[15:8]};
        @(posedge mclk);
        acq_done <= 3'h0;
        @(posedge mclk);
    endtask

    // Read racing an acquisition: lead 0 puts the completion one edge before the edge
    // that takes the read, lead 1 puts it on that same edge
    task rdacq(input logic [7:0] a, input logic [2:0] mask, input logic [15:0] v,
               input int lead, input logic [7:0] exp_d, input logic [7:0] exp_s);
        int n;
        @(posedge mclk);
        req      <= 1'b1;
        req_addr <= a;
        repeat (lead) @(posedge mclk);
        acq_done <= mask;
        dx       <= v;
        dy       <= ~v;
        dz       <= {v[7:0], v[15:8]};
        @(posedge mclk);
        acq_done <= 3'h0;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            fails++;
            end_sim();
        end
        req <= 1'b0;
        chk("rd_data", rdata, exp_d);
        chk("status", status, exp_s);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_idle;
        chk("status", status, 8'h00);
        rdchk(8'h32, 8'h00, 8'h00);
        rdchk(8'h40, 8'h00, 8'h00);
        rdchk(8'h34, 8'h00, 8'h00);
        $display("test idle done");
    endtask

    task t_set;
        acq(3'h7, 16'h1234);
        chk("status", status, 8'h0f);
        rdchk(8'h32, 8'h0f, 8'h0f);
        rdchk(8'h33, 8'h12, 8'h0e);
        rdchk(8'h34, 8'h34, 8'h0e);
        rdchk(8'h35, 8'hed, 8'h0c);
        rdchk(8'h37, 8'h34, 8'h00);
        rdchk(8'h36, 8'hcb, 8'h00);
        rdchk(8'h38, 8'h12, 8'h00);
        $display("test ready done");
    endtask

    task t_ow;
        acq(3'h1, 16'h1111);
        chk("status", status, 8'h01);
        acq(3'h1, 16'h2222);
        chk("status", status, 8'h91);
        rdchk(8'h33, 8'h22, 8'h80);
        acq(3'h2, 16'h3333);
        chk("status", status, 8'h82);
        acq(3'h2, 16'h4444);
        chk("status", status, 8'ha2);
        acq(3'h4, 16'h5555);
        chk("status", status, 8'hae);
        acq(3'h4, 16'h6666);
        chk("status", status, 8'hee);
        rdchk(8'h32, 8'hee, 8'hee);
        rdchk(8'h33, 8'h22, 8'hee);
        rdchk(8'h35, 8'hbb, 8'hcc);
        rdchk(8'h37, 8'h66, 8'h00);
        $display("test overwrite done");
    endtask

    task t_rst;
        acq(3'h7, 16'h0f0f);
        rst_b <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        chk("status", status, 8'h00);
        rst_b <= 1'b1;
        rdchk(8'h33, 8'h00, 8'h00);
        $display("test reset done");
    endtask

    // Set must win over a same-cycle high-byte clear, for ready and overwrite alike
    task t_race;
        rdacq(8'h33, 3'h1, 16'h5a5a, 0, 8'h5a, 8'h00);
        rdacq(8'h33, 3'h1, 16'ha5a5, 1, 8'h5a, 8'h01);
        rdacq(8'h33, 3'h1, 16'h0101, 1, 8'ha5, 8'h91);
        rdchk(8'h33, 8'h01, 8'h80);
        rdchk(8'h35, 8'h00, 8'h80);
        rdchk(8'h37, 8'h00, 8'h00);
        $display("test race done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_idle();
        t_set();
        t_ow();
        t_rst();
        t_race();
        end_sim();
    end
endmodule
